//--- icc_defs.svh
// Offsets, bit positions, reset values and encodings for the indirect configuration block.
//
// Operation
// - Bit 0 of the control and status register returns the downstream ownership semaphore and reading it never changes it.
// - Bit 8 of the control and status register returns the upstream ownership semaphore and reading it never changes it.
// - Bit 1 is a read/write downstream enable, reset to zero, that lets a downstream data register access launch a secondary configuration cycle.
// - While the downstream enable is zero, no secondary configuration cycle starts and the downstream data register is reserved.
// - Bit 9 is a read/write upstream enable, reset to zero, that lets an upstream data register access launch a primary configuration cycle.
// - While the upstream enable is zero, no primary configuration cycle starts and the upstream data register is reserved.
// - Bits 7 to 2 and 15 to 10 of the control and status register always read as zero.
// - The control and status register answers at the same byte pair in both configuration spaces and at its own offset in the memory and I/O window.
// - The first chip control register accepts values from a serial ROM or the local processor before host configuration.
// - With master-abort mode zero, a master-aborted delayed transaction completes to the initiator with TRDY# and all-ones read data.
// - With master-abort mode one, the initiator's repeated request for a master-aborted delayed transaction gets a target abort.
// - The memory write disconnect setting governs ordinary memory writes only and never memory write and invalidate.
// - A primary read of the downstream semaphore as zero while the downstream enable is one then sets the semaphore.
// - A semaphore clears by itself once its indirect configuration transaction has finished on the initiator bus.
// - An enabled data register access starts the transaction and is retried until it has completed on the target bus.
`ifndef ICC_DEFS_SVH
`define ICC_DEFS_SVH

`define ICC_CFG_OWN_OFS 8'h90
`define ICC_CFG_CCS_OFS 8'h92
`define ICC_CFG_CC0_OFS 8'hcc
`define ICC_CSR_OWN_OFS 12'h010
`define ICC_CSR_CCS_OFS 12'h012

`define ICC_DS_OWN_BIT 0
`define ICC_DS_EN_BIT 1
`define ICC_US_OWN_BIT 8
`define ICC_US_EN_BIT 9
`define ICC_MA_MODE_BIT 0
`define ICC_MWD_BIT 1

`define ICC_CCS_RST 16'h0000
`define ICC_CC0_RST 16'h0000
`define ICC_MA_RDATA 32'hffffffff
`define ICC_CMD_MEM_WR 4'h7
`define ICC_CMD_MEM_WRINV 4'hf

`endif

//--- icc_pkg.sv
// Types shared by the indirect configuration block.
package icc_pkg;

  // Progress of one indirect configuration transaction.
  typedef enum logic [1:0] {
    ICC_IDLE = 2'b00,
    ICC_BUSY = 2'b01,
    ICC_DONE = 2'b10
  } icc_xfer_t;

endpackage

//--- icc_lane.sv
// One direction of indirect configuration: ownership semaphore and transaction tracking.
`timescale 1ns/100ps
`include "icc_defs.svh"
module icc_lane
  import icc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic en,
  input wire logic grab,
  input wire logic acc,
  input wire logic tgt_done,
  output logic own,
  output logic start,
  output logic retry,
  output logic complete
);

  icc_xfer_t st_q, st_d;
  logic own_q, own_d;
  logic start_q;
  wire take = acc & en;

  // Access while idle launches and is retried, while busy is retried, once done completes.
  assign retry = take & (st_q != ICC_DONE);
  assign complete = take & (st_q == ICC_DONE);

  always_comb begin
    st_d = st_q;
    case (st_q)
      ICC_IDLE: begin
        if (take) begin
          st_d = ICC_BUSY;
        end
      end
      ICC_BUSY: begin
        if (tgt_done) begin
          st_d = ICC_DONE;
        end
      end
      ICC_DONE: begin
        if (take) begin
          st_d = ICC_IDLE;
        end
      end
      default: begin
        st_d = ICC_IDLE;
      end
    endcase
  end

  // A grant on a zero read wins over the clear of a finished transaction.
  assign own_d = (grab & en & ~own_q) ? 1'b1 : (complete ? 1'b0 : own_q);

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= ICC_IDLE;
      own_q <= 1'b0;
      start_q <= 1'b0;
    end else if (ce) begin
      st_q <= st_d;
      own_q <= own_d;
      start_q <= take & (st_q == ICC_IDLE);
    end
  end

  assign own = own_q;
  assign start = start_q;

endmodule

//--- icc_mabort.sv
// Initiator-side answer to a master-aborted delayed transaction, and write disconnect select.
`timescale 1ns/100ps
`include "icc_defs.svh"
module icc_mabort
  import icc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic ma_mode,
  input wire logic mwd,
  input wire logic dt_mabort,
  input wire logic rpt,
  input wire logic rpt_read,
  input wire logic [3:0] wr_cmd,
  output logic trdy,
  output logic tabort,
  output logic [31:0] rdata,
  output logic cl_disc
);

  logic pend_q;
  logic [31:0] rdata_q;

  // The repeated request is answered in the cycle it arrives.
  assign trdy = rpt & pend_q & ~ma_mode;
  assign tabort = rpt & pend_q & ma_mode;

  // Cache line disconnect applies to plain memory writes only.
  assign cl_disc = mwd & (wr_cmd == `ICC_CMD_MEM_WR);

  // A new abort arriving with the answer keeps the pending flag set.
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else if (ce) begin
      pend_q <= dt_mabort | (pend_q & ~rpt);
      if (rpt & pend_q & ~ma_mode & rpt_read) begin
        rdata_q <= `ICC_MA_RDATA;
      end
    end
  end

  assign rdata = rdata_q;

endmodule

//--- icc_top.sv
// Indirect configuration control and status register bank with master-abort handling.
`timescale 1ns/100ps
`include "icc_defs.svh"
module icc_top
  import icc_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic CE,
  // Primary configuration space access.
  input wire logic P_CFG_REQ,
  input wire logic P_CFG_WR,
  input wire logic [7:0] P_CFG_ADDR,
  input wire logic [3:0] P_CFG_BE,
  input wire logic [31:0] P_CFG_WDATA,
  output logic [31:0] P_CFG_RDATA,
  output logic P_CFG_ACK,
  // Secondary configuration space access.
  input wire logic S_CFG_REQ,
  input wire logic S_CFG_WR,
  input wire logic [7:0] S_CFG_ADDR,
  input wire logic [3:0] S_CFG_BE,
  input wire logic [31:0] S_CFG_WDATA,
  output logic [31:0] S_CFG_RDATA,
  output logic S_CFG_ACK,
  // Memory and I/O mapped register window.
  input wire logic CSR_REQ,
  input wire logic CSR_WR,
  input wire logic [11:0] CSR_ADDR,
  input wire logic [3:0] CSR_BE,
  input wire logic [31:0] CSR_WDATA,
  output logic [31:0] CSR_RDATA,
  output logic CSR_ACK,
  // Chip control preload paths.
  input wire logic SROM_LOAD,
  input wire logic [15:0] SROM_DATA,
  input wire logic LP_WR,
  input wire logic [15:0] LP_DATA,
  // Downstream data register accesses and secondary-bus transaction.
  input wire logic DS_DATA_ACC,
  input wire logic DS_DATA_FROM_S,
  input wire logic DS_TGT_DONE,
  output logic DS_CFG_START,
  output logic DS_RETRY,
  output logic DS_RSVD,
  output logic DS_COMPLETE,
  // Upstream data register accesses and primary-bus transaction.
  input wire logic US_DATA_ACC,
  input wire logic US_DATA_FROM_P,
  input wire logic US_TGT_DONE,
  output logic US_CFG_START,
  output logic US_RETRY,
  output logic US_RSVD,
  output logic US_COMPLETE,
  // Delayed transactions forwarded downstream, answered on the primary bus.
  input wire logic P_DT_MABORT,
  input wire logic P_RPT,
  input wire logic P_RPT_READ,
  input wire logic [3:0] P_WR_CMD,
  output logic P_TRDY,
  output logic P_TABORT,
  output logic [31:0] P_RESP_DATA,
  output logic P_CL_DISC,
  // Delayed transactions forwarded upstream, answered on the secondary bus.
  input wire logic S_DT_MABORT,
  input wire logic S_RPT,
  input wire logic S_RPT_READ,
  input wire logic [3:0] S_WR_CMD,
  output logic S_TRDY,
  output logic S_TABORT,
  output logic [31:0] S_RESP_DATA,
  output logic S_CL_DISC
);

  logic ds_en_q, us_en_q;
  logic [15:0] cc0_q, cc0_d;
  logic ds_own, us_own;
  logic [31:0] p_rd_q, s_rd_q, csr_rd_q;
  logic p_ack_q, s_ack_q, csr_ack_q;

  // Dword decode of each access path.
  wire p_hit_own = P_CFG_ADDR[7:2] == 6'(`ICC_CFG_OWN_OFS >> 2);
  wire p_hit_ccs = P_CFG_ADDR[7:2] == 6'(`ICC_CFG_CCS_OFS >> 2);
  wire p_hit_cc0 = P_CFG_ADDR[7:2] == 6'(`ICC_CFG_CC0_OFS >> 2);
  wire s_hit_own = S_CFG_ADDR[7:2] == 6'(`ICC_CFG_OWN_OFS >> 2);
  wire s_hit_ccs = S_CFG_ADDR[7:2] == 6'(`ICC_CFG_CCS_OFS >> 2);
  wire s_hit_cc0 = S_CFG_ADDR[7:2] == 6'(`ICC_CFG_CC0_OFS >> 2);
  wire c_hit_own = CSR_ADDR[11:2] == 10'(`ICC_CSR_OWN_OFS >> 2);
  wire c_hit_ccs = CSR_ADDR[11:2] == 10'(`ICC_CSR_CCS_OFS >> 2);

  // Byte lane of the control and status pair inside its dword.
  wire [1:0] p_ccs_be = P_CFG_BE[3:2];
  wire [1:0] s_ccs_be = S_CFG_BE[3:2];
  wire [1:0] c_ccs_be = CSR_BE[3:2];

  // Write strobes into the control and status register.
  wire p_ccs_wr = P_CFG_REQ & P_CFG_WR & p_hit_ccs;
  wire s_ccs_wr = S_CFG_REQ & S_CFG_WR & s_hit_ccs;
  wire c_ccs_wr = CSR_REQ & CSR_WR & c_hit_ccs;

  // Write strobes into the chip control register from configuration space.
  wire p_cc0_wr = P_CFG_REQ & P_CFG_WR & p_hit_cc0;
  wire s_cc0_wr = S_CFG_REQ & S_CFG_WR & s_hit_cc0;

  // Status image with reserved bits held at zero.
  wire [15:0] ccs_img = {6'h00, us_en_q, us_own, 6'h00, ds_en_q, ds_own};
  wire [15:0] own_img = {7'h00, us_own, 7'h00, ds_own};

  // Read images of each dword seen by each path.
  wire [31:0] ccs_dw = {ccs_img, own_img};
  wire [31:0] cc0_dw = {16'h0000, cc0_q};

  // Semaphore reads that can grant ownership. Reads of bits 0 and 8 in the
  // status pair are side-effect free, only a read enabling byte lane 0 (downstream) or 1 (upstream) grants.
  wire ds_grab = P_CFG_REQ & ~P_CFG_WR & p_hit_own & P_CFG_BE[0];
  wire us_grab = S_CFG_REQ & ~S_CFG_WR & s_hit_own & S_CFG_BE[1];

  // Read data selection; unmapped dwords read as zero.
  wire [31:0] p_rd_d = (p_hit_own | p_hit_ccs) ? ccs_dw : (p_hit_cc0 ? cc0_dw : 32'h00000000);
  wire [31:0] s_rd_d = (s_hit_own | s_hit_ccs) ? ccs_dw : (s_hit_cc0 ? cc0_dw : 32'h00000000);
  wire [31:0] c_rd_d = (c_hit_own | c_hit_ccs) ? ccs_dw : 32'h00000000;

  // New value of the downstream enable; primary wins over secondary over window.
  wire ds_en_d = (p_ccs_wr & p_ccs_be[0]) ? P_CFG_WDATA[16 + `ICC_DS_EN_BIT] :
                 (s_ccs_wr & s_ccs_be[0]) ? S_CFG_WDATA[16 + `ICC_DS_EN_BIT] :
                 (c_ccs_wr & c_ccs_be[0]) ? CSR_WDATA[16 + `ICC_DS_EN_BIT] : ds_en_q;

  // New value of the upstream enable with the same priority.
  wire us_en_d = (p_ccs_wr & p_ccs_be[1]) ? P_CFG_WDATA[16 + `ICC_US_EN_BIT] :
                 (s_ccs_wr & s_ccs_be[1]) ? S_CFG_WDATA[16 + `ICC_US_EN_BIT] :
                 (c_ccs_wr & c_ccs_be[1]) ? CSR_WDATA[16 + `ICC_US_EN_BIT] : us_en_q;

  // Chip control sources: preload first, then local processor, then each bus.
  always_comb begin
    cc0_d = cc0_q;
    if (SROM_LOAD) begin
      cc0_d = SROM_DATA;
    end else if (LP_WR) begin
      cc0_d = LP_DATA;
    end else if (p_cc0_wr) begin
      cc0_d[7:0] = P_CFG_BE[0] ? P_CFG_WDATA[7:0] : cc0_q[7:0];
      cc0_d[15:8] = P_CFG_BE[1] ? P_CFG_WDATA[15:8] : cc0_q[15:8];
    end else if (s_cc0_wr) begin
      cc0_d[7:0] = S_CFG_BE[0] ? S_CFG_WDATA[7:0] : cc0_q[7:0];
      cc0_d[15:8] = S_CFG_BE[1] ? S_CFG_WDATA[15:8] : cc0_q[15:8];
    end
  end

  // Register state and read answers, one cycle after each request.
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      ds_en_q <= 1'(`ICC_CCS_RST >> `ICC_DS_EN_BIT);
      us_en_q <= 1'(`ICC_CCS_RST >> `ICC_US_EN_BIT);
      cc0_q <= `ICC_CC0_RST;
      p_rd_q <= 32'h00000000;
      s_rd_q <= 32'h00000000;
      csr_rd_q <= 32'h00000000;
      p_ack_q <= 1'b0;
      s_ack_q <= 1'b0;
      csr_ack_q <= 1'b0;
    end else if (CE) begin
      ds_en_q <= ds_en_d;
      us_en_q <= us_en_d;
      cc0_q <= cc0_d;
      p_ack_q <= P_CFG_REQ;
      s_ack_q <= S_CFG_REQ;
      csr_ack_q <= CSR_REQ;
      if (P_CFG_REQ & ~P_CFG_WR) begin
        p_rd_q <= p_rd_d;
      end
      if (S_CFG_REQ & ~S_CFG_WR) begin
        s_rd_q <= s_rd_d;
      end
      if (CSR_REQ & ~CSR_WR) begin
        csr_rd_q <= c_rd_d;
      end
    end
  end

  assign P_CFG_RDATA = p_rd_q;
  assign S_CFG_RDATA = s_rd_q;
  assign CSR_RDATA = csr_rd_q;
  assign P_CFG_ACK = p_ack_q;
  assign S_CFG_ACK = s_ack_q;
  assign CSR_ACK = csr_ack_q;

  // A data access from the wrong side or while disabled is reserved.
  wire ds_acc_ok = DS_DATA_ACC & ~DS_DATA_FROM_S;
  wire us_acc_ok = US_DATA_ACC & ~US_DATA_FROM_P;
  assign DS_RSVD = DS_DATA_ACC & (DS_DATA_FROM_S | ~ds_en_q);
  assign US_RSVD = US_DATA_ACC & (US_DATA_FROM_P | ~us_en_q);

  // Downstream semaphore and secondary-bus transaction tracking.
  icc_lane u_ds_lane (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .ce(CE),
    .en(ds_en_q),
    .grab(ds_grab),
    .acc(ds_acc_ok),
    .tgt_done(DS_TGT_DONE),
    .own(ds_own),
    .start(DS_CFG_START),
    .retry(DS_RETRY),
    .complete(DS_COMPLETE)
  );

  // Upstream semaphore and primary-bus transaction tracking.
  icc_lane u_us_lane (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .ce(CE),
    .en(us_en_q),
    .grab(us_grab),
    .acc(us_acc_ok),
    .tgt_done(US_TGT_DONE),
    .own(us_own),
    .start(US_CFG_START),
    .retry(US_RETRY),
    .complete(US_COMPLETE)
  );

  // Primary initiators whose transactions went downstream.
  icc_mabort u_p_mabort (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .ce(CE),
    .ma_mode(cc0_q[`ICC_MA_MODE_BIT]),
    .mwd(cc0_q[`ICC_MWD_BIT]),
    .dt_mabort(P_DT_MABORT),
    .rpt(P_RPT),
    .rpt_read(P_RPT_READ),
    .wr_cmd(P_WR_CMD),
    .trdy(P_TRDY),
    .tabort(P_TABORT),
    .rdata(P_RESP_DATA),
    .cl_disc(P_CL_DISC)
  );

  // Secondary initiators whose transactions went upstream.
  icc_mabort u_s_mabort (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .ce(CE),
    .ma_mode(cc0_q[`ICC_MA_MODE_BIT]),
    .mwd(cc0_q[`ICC_MWD_BIT]),
    .dt_mabort(S_DT_MABORT),
    .rpt(S_RPT),
    .rpt_read(S_RPT_READ),
    .wr_cmd(S_WR_CMD),
    .trdy(S_TRDY),
    .tabort(S_TABORT),
    .rdata(S_RESP_DATA),
    .cl_disc(S_CL_DISC)
  );

endmodule

//--- icc_top_asserts.sv
// Port-level assertions for the indirect configuration block.
`timescale 1ns/100ps
module icc_top_asserts (
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic CE,
  input wire logic P_CFG_REQ,
  input wire logic P_CFG_ACK,
  input wire logic CSR_REQ,
  input wire logic CSR_ACK,
  input wire logic DS_DATA_ACC,
  input wire logic DS_DATA_FROM_S,
  input wire logic DS_RETRY,
  input wire logic DS_RSVD,
  input wire logic DS_COMPLETE,
  input wire logic DS_CFG_START,
  input wire logic US_DATA_ACC,
  input wire logic US_DATA_FROM_P,
  input wire logic US_RSVD,
  input wire logic P_RPT,
  input wire logic P_RPT_READ,
  input wire logic P_TRDY,
  input wire logic P_TABORT,
  input wire logic [31:0] P_RESP_DATA,
  input wire logic [3:0] P_WR_CMD,
  input wire logic P_CL_DISC
);
  // All checks share the one clock and its reset.
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  // Named steps of a launch and of an aborted read answer.
  sequence ds_pulse_s; DS_CFG_START ##1 !DS_CFG_START; endsequence
  sequence ma_rd_s; P_TRDY && P_RPT_READ; endsequence
  a_p_ack_next: assert property (CE && P_CFG_REQ |=> P_CFG_ACK)
    else $error("Primary access not acknowledged in one cycle.");
  a_csr_ack_match: assert property (CSR_ACK == $past(CSR_REQ && CE))
    else $error("Window acknowledge does not follow its request.");
  a_ds_wrong_side: assert property (DS_DATA_ACC && DS_DATA_FROM_S |-> DS_RSVD ##1 !DS_CFG_START)
    else $error("Downstream access from secondary not reserved.");
  a_us_wrong_side: assert property (US_DATA_ACC && US_DATA_FROM_P |-> US_RSVD)
    else $error("Upstream access from primary not reserved.");
  a_ds_launch_once: assert property (DS_CFG_START |-> $past(DS_RETRY) ##0 ds_pulse_s)
    else $error("Downstream launch without a retried access.");
  a_ds_one_answer: assert property ($onehot0({DS_RETRY, DS_RSVD, DS_COMPLETE}))
    else $error("Downstream access given two answers.");
  a_ma_read_ones: assert property (ma_rd_s |=> P_RESP_DATA == 32'hffffffff)
    else $error("Aborted read did not return all ones.");
  a_ma_single_answer: assert property (P_TRDY || P_TABORT |-> P_RPT && !(P_TRDY && P_TABORT))
    else $error("Abort answer without a repeat or doubled.");
  a_mwi_no_disc: assert property (P_WR_CMD == 4'hf |-> !P_CL_DISC)
    else $error("Write and invalidate took the cache line disconnect.");
endmodule
bind icc_top icc_top_asserts u_chk (.*);

//--- icc_tgt_model.sv
// Target-bus model that finishes a launched configuration cycle after a set delay.
`timescale 1ns/100ps
module icc_tgt_model #(parameter int DLY = 4) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  output logic done
);
  int cnt_q;
  // Counts down from a launch and pulses done for one cycle at the end.
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= 0;
      done <= 1'b0;
    end else begin
      done <= (cnt_q == 1);
      cnt_q <= start ? DLY : (cnt_q != 0 ? cnt_q - 1 : 0);
    end
  end
endmodule

//--- indirect_config_control_status_tb.sv
// Self-checking bench for the indirect configuration block.
`timescale 1ns/100ps
module indirect_config_control_status_tb;
  typedef struct packed {
    logic [1:0] port;
    logic wr;
    logic [11:0] addr;
    logic [3:0] be;
    logic [31:0] wd;
    logic [31:0] exp;
  } icc_row_t;
  logic CLK_SYS = '0, SYS_RST = '1, CE = '1, SROM_LOAD = '0, LP_WR = '0;
  logic P_CFG_REQ = '0, P_CFG_WR = '0, S_CFG_REQ = '0, S_CFG_WR = '0, CSR_REQ = '0, CSR_WR = '0;
  logic [7:0] P_CFG_ADDR = '0, S_CFG_ADDR = '0;
  logic [11:0] CSR_ADDR = '0;
  logic [3:0] P_CFG_BE = '0, S_CFG_BE = '0, CSR_BE = '0, P_WR_CMD = '0, S_WR_CMD = '0;
  logic [31:0] P_CFG_WDATA = '0, S_CFG_WDATA = '0, CSR_WDATA = '0;
  logic [15:0] SROM_DATA = '0, LP_DATA = '0;
  logic DS_DATA_ACC = '0, DS_DATA_FROM_S = '0, US_DATA_ACC = '0, US_DATA_FROM_P = '0;
  logic P_DT_MABORT = '0, P_RPT = '0, P_RPT_READ = '0, S_DT_MABORT = '0, S_RPT = '0;
  logic S_RPT_READ = '0;
  logic [31:0] P_CFG_RDATA, S_CFG_RDATA, CSR_RDATA, P_RESP_DATA, S_RESP_DATA;
  logic P_CFG_ACK, S_CFG_ACK, CSR_ACK, DS_TGT_DONE, US_TGT_DONE, DS_CFG_START, DS_RETRY;
  logic DS_RSVD, DS_COMPLETE, US_CFG_START, US_RETRY, US_RSVD, US_COMPLETE;
  logic P_TRDY, P_TABORT, P_CL_DISC, S_TRDY, S_TABORT, S_CL_DISC;
  int bad_count = 0, check_count = 0, cyc = 0;
  icc_row_t rows [15];
  // Design, with a slow far side downstream and a prompt one upstream.
  always #5 CLK_SYS = ~CLK_SYS;
  icc_top dut (.*);
  icc_tgt_model #(.DLY(6)) ds_tgt (.clk(CLK_SYS), .rst(SYS_RST), .start(DS_CFG_START),
    .done(DS_TGT_DONE));
  icc_tgt_model #(.DLY(1)) us_tgt (.clk(CLK_SYS), .rst(SYS_RST), .start(US_CFG_START),
    .done(US_TGT_DONE));
  task automatic finish_test();
    if (bad_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick();
    @(posedge CLK_SYS);
    #1;
  endtask
  // One register access on the port the row names, acknowledge and read data compared.
  task automatic acc(input icc_row_t r);
    logic [31:0] rd;
    {P_CFG_WR, S_CFG_WR, CSR_WR} = {3{r.wr}};
    {P_CFG_ADDR, S_CFG_ADDR, CSR_ADDR} = {r.addr[7:0], r.addr[7:0], r.addr};
    {P_CFG_BE, S_CFG_BE, CSR_BE} = {3{r.be}};
    {P_CFG_WDATA, S_CFG_WDATA, CSR_WDATA} = {3{r.wd}};
    {P_CFG_REQ, S_CFG_REQ, CSR_REQ} = {r.port == 2'h0, r.port == 2'h1, r.port == 2'h2};
    tick();
    {P_CFG_REQ, S_CFG_REQ, CSR_REQ} = '0;
    check(32'(r.port == 2'h0 ? P_CFG_ACK : r.port == 2'h1 ? S_CFG_ACK : CSR_ACK), 32'h1);
    rd = r.port == 2'h0 ? P_CFG_RDATA : r.port == 2'h1 ? S_CFG_RDATA : CSR_RDATA;
    if (!r.wr) check(rd, r.exp);
    tick();
  endtask
  // One data register access; exp holds retry, reserved, complete and launch.
  task automatic lane(input logic up, input logic wrong, input logic [3:0] exp);
    logic [3:0] v;
    {DS_DATA_ACC, US_DATA_ACC, DS_DATA_FROM_S, US_DATA_FROM_P} = {!up, up, wrong, wrong};
    #1;
    v[3:1] = up ? {US_RETRY, US_RSVD, US_COMPLETE} : {DS_RETRY, DS_RSVD, DS_COMPLETE};
    tick();
    {DS_DATA_ACC, US_DATA_ACC} = '0;
    v[0] = up ? US_CFG_START : DS_CFG_START;
    check(32'(v), 32'(exp));
    tick();
  endtask
  // One master-aborted delayed transaction on one side, answered on its repeat.
  task automatic ma(input logic s, input logic [1:0] exp);
    {P_DT_MABORT, S_DT_MABORT} = {!s, s};
    tick();
    {P_DT_MABORT, S_DT_MABORT} = '0;
    tick();
    {P_RPT, P_RPT_READ, S_RPT, S_RPT_READ} = {!s, !s, s, s};
    #1;
    check(32'(s ? {S_TRDY, S_TABORT} : {P_TRDY, P_TABORT}), 32'(exp));
    tick();
    {P_RPT, P_RPT_READ, S_RPT, S_RPT_READ} = '0;
    if (exp[1]) check(s ? S_RESP_DATA : P_RESP_DATA, 32'hffffffff);
    tick();
  endtask
  // Cuts a hung run short.
  always @(posedge CLK_SYS) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      finish_test();
    end
  end
  // Main sequence: table of register accesses, then lanes, aborts, preloads and reset.
  initial begin
    rows = '{'{2'h0, 1'b0, 12'h090, 4'hf, 32'h0, 32'h0},
      '{2'h0, 1'b1, 12'h090, 4'hc, 32'h02020000, 32'h0},
      '{2'h1, 1'b0, 12'h090, 4'hc, 32'h0, 32'h02020000},
      '{2'h2, 1'b0, 12'h010, 4'hf, 32'h0, 32'h02020000},
      '{2'h2, 1'b1, 12'h010, 4'hc, 32'hffff0000, 32'h0},
      '{2'h0, 1'b0, 12'h090, 4'hc, 32'h0, 32'h02020000},
      '{2'h0, 1'b0, 12'h090, 4'hf, 32'h0, 32'h02020000},
      '{2'h1, 1'b0, 12'h090, 4'hc, 32'h0, 32'h02030001},
      '{2'h1, 1'b0, 12'h090, 4'hc, 32'h0, 32'h02030001},
      '{2'h1, 1'b0, 12'h090, 4'h2, 32'h0, 32'h02030001},
      '{2'h0, 1'b0, 12'h090, 4'hc, 32'h0, 32'h03030101},
      '{2'h0, 1'b1, 12'h0cc, 4'h3, 32'h1, 32'h0},
      '{2'h1, 1'b0, 12'h0cc, 4'hf, 32'h0, 32'h1},
      '{2'h0, 1'b0, 12'h040, 4'hf, 32'h0, 32'h0},
      '{2'h2, 1'b0, 12'h0cc, 4'hf, 32'h0, 32'h0}};
    repeat (12) tick();
    SYS_RST = '0;
    foreach (rows[i]) acc(rows[i]);
    lane(1'b0, 1'b1, 4'b0100);
    lane(1'b1, 1'b1, 4'b0100);
    lane(1'b0, 1'b0, 4'b1001);
    lane(1'b0, 1'b0, 4'b1000);
    repeat (10) tick();
    lane(1'b0, 1'b0, 4'b0010);
    acc('{2'h2, 1'b0, 12'h010, 4'hc, 32'h0, 32'h03020100});
    lane(1'b1, 1'b0, 4'b1001);
    repeat (4) tick();
    lane(1'b1, 1'b0, 4'b0010);
    acc('{2'h2, 1'b0, 12'h010, 4'hc, 32'h0, 32'h02020000});
    acc('{2'h0, 1'b1, 12'h090, 4'hc, 32'h0, 32'h0});
    lane(1'b0, 1'b0, 4'b0100);
    lane(1'b1, 1'b0, 4'b0100);
    ma(1'b0, 2'b01);
    {SROM_DATA, LP_DATA} = {16'h0000, 16'h0002};
    LP_WR = '1;
    tick();
    LP_WR = '0;
    acc('{2'h0, 1'b0, 12'h0cc, 4'hf, 32'h0, 32'h2});
    ma(1'b1, 2'b10);
    ma(1'b0, 2'b10);
    {P_WR_CMD, S_WR_CMD} = 8'h77;
    #1;
    check(32'({P_CL_DISC, S_CL_DISC}), 32'h3);
    {P_WR_CMD, S_WR_CMD} = 8'hff;
    #1;
    check(32'({P_CL_DISC, S_CL_DISC}), 32'h0);
    SROM_LOAD = '1;
    tick();
    SROM_LOAD = '0;
    acc('{2'h1, 1'b0, 12'h0cc, 4'hf, 32'h0, 32'h0});
    acc('{2'h0, 1'b1, 12'h090, 4'hc, 32'h02020000, 32'h0});
    SYS_RST = '1;
    repeat (2) tick();
    SYS_RST = '0;
    acc('{2'h0, 1'b0, 12'h090, 4'hc, 32'h0, 32'h0});
    finish_test();
  end
endmodule
